//--- dtc_cfg.svh
/*
  constants of the display terminal counter block: register offsets,
  field positions, reset values and timing counts.
  assumes a 200 MHz clk_i and a 32-bit classic Wishbone register bus.
*/
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// register byte offsets
`define DTC_CTRL_OFS 8'h00
`define DTC_STAT_OFS 8'h04
`define DTC_EVT_OFS 8'h08
`define DTC_HOURS_OFS 8'h0C
`define DTC_DISP_OFS 8'h10
`define DTC_GLYPH_OFS 8'h14
`define DTC_NVLOAD_OFS 8'h18
`define DTC_TIMER_OFS 8'h20
`define DTC_COUNT_OFS 8'h30
`define DTC_CHAR_OFS 8'h40
// readback regions, picked by address bits 7:6
`define DTC_CHAR_RD_SEL 2'h1
`define DTC_GLYPH_RD_SEL 2'h2

// field positions
`define DTC_CTRL_TEN_LSB 0
`define DTC_CTRL_TCLR_LSB 4
`define DTC_CTRL_CCLR_LSB 8
`define DTC_CTRL_SAVE_BIT 12
`define DTC_CTRL_LIGHT_BIT 13
`define DTC_CTRL_RESTORE_BIT 14
`define DTC_STAT_BTN_LSB 0
`define DTC_STAT_SCROLL0_BIT 5
`define DTC_STAT_SCROLL1_BIT 6
`define DTC_STAT_READY_BIT 7

// reset values
`define DTC_CTRL_RST 32'h0000_0000
`define DTC_ROW_LEN_RST 6'h10

// display geometry
`define DTC_ROW_CELLS 16
`define DTC_MAX_ROW_LEN 32

// timing
`define DTC_CLK_HZ 200000000
`define DTC_SECOND_S 1
`define DTC_SAVE_MIN 15
`define DTC_SEC_CYC (`DTC_CLK_HZ * `DTC_SECOND_S)
`define DTC_SAVE_SEC (`DTC_SAVE_MIN * 60)

`endif

//--- dtc_pkg.sv
/*
  types of the display terminal counter block.
  assumes dtc_cfg.svh supplies all numeric constants.
*/
package dtc_pkg;
  // non-volatile save sequencer states
  typedef enum logic [1:0] {
    DTC_NV_IDLE,
    DTC_NV_WRITE,
    DTC_NV_LOAD
  } dtc_nv_state_t;
  // one 32-bit count word
  typedef logic [31:0] dtc_word_t;
endpackage

//--- dtc_top.sv
/*
  display terminal counters: four second timers, four edge counters, an
  operating-hours counter, button inputs, display row and glyph store,
  backlight, and a word-serial non-volatile save/restore port.
  assumes a classic Wishbone master, a non-volatile store that takes one
  word per clock cycle with nv_we_o high, and button pins asynchronous to clk_i.
*/
`timescale 1ns/1ps
`include "dtc_cfg.svh"
`default_nettype none
module dtc_top
  import dtc_pkg::*;
#(
  parameter int SEC_CYC = `DTC_SEC_CYC, // cycles per second, shorten in sim
  parameter int SAVE_SEC = `DTC_SAVE_SEC // seconds between automatic saves
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // navigation buttons: up, down, left, right, enter
  input wire logic [4:0] btn_i,
  // display outputs
  output logic light_o,
  output logic [31:0] hours_disp_o,
  // non-volatile store port: 9 words, index 0-3 timers, 4-7 counters, 8 hours
  output logic nv_we_o,
  output logic [3:0] nv_idx_o,
  output logic [31:0] nv_wdata_o,
  input wire logic [31:0] nv_rdata_i
);

////////////////////////////////////////////////////////////////////////
// registers
  logic [31:0] ctrl_r; // enables, backlight
  logic [3:0] evt_r; // event bits from controller
  logic [3:0] evt_d_r; // previous event bits for edge detect
  logic [5:0] row_len_r [2]; // supplied text length per row
  logic [7:0] chars_r [32]; // two rows of up to 16 cells
  logic [7:0] glyph_r [16]; // two glyphs, 8 rows of 5 pixels
  dtc_word_t timer_r [4];
  dtc_word_t count_r [4];
  dtc_word_t hours_r;
  logic [4:0] btn_r; // debounced button state
  logic [31:0] sec_cnt_r; // second prescaler
  logic sec_tick_r; // one-cycle pulse per second
  logic [31:0] save_cnt_r; // seconds since the last auto save
  logic save_req_r; // pending save, set wins over clear
  dtc_nv_state_t nv_state_r;
  logic [3:0] nv_idx_r;
  logic ready_r; // counting allowed after restore
  logic wb_hit; // valid strobe this cycle
  logic wr_en;
  logic ctrl_wr; // control word written this cycle with both low byte enables set

  assign wb_hit = cyc_i & stb_i & ~ack_o;
  assign wr_en = wb_hit & we_i;
  assign ctrl_wr = wr_en && adr_i == `DTC_CTRL_OFS && sel_i[1:0] == 2'h3;

////////////////////////////////////////////////////////////////////////
// button synchroniser: three stages, change taken when stage 2 and 3 agree
  logic [4:0] b1_r, b2_r, b3_r; // stage 1 is read by stage 2 only
  always_ff @(posedge clk_i)
  begin
    b1_r <= btn_i;
    b2_r <= b1_r;
    b3_r <= b2_r;
  end

  // debounced state, published in status
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      btn_r <= 5'h00;
    else
      btn_r <= (b2_r == b3_r) ? b3_r : btn_r;
  end

////////////////////////////////////////////////////////////////////////
// one-second timebase
  // prescaler runs through the restore; ticks are held back until ready
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sec_cnt_r == 32'(SEC_CYC - 1))
      sec_cnt_r <= 32'h0000_0000;
    else
      sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
    sec_tick_r <= !rst_i && ready_r && sec_cnt_r == 32'(SEC_CYC - 1);
  end

////////////////////////////////////////////////////////////////////////
// control register and event bits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_r <= `DTC_CTRL_RST;
      evt_r <= 4'h0;
    end
    else if (ctrl_wr)
      ctrl_r <= dat_i & 32'h0000_200F; // clear and save bits are strobes, not stored
    else if (wr_en && adr_i == `DTC_EVT_OFS && sel_i[0])
      evt_r <= dat_i[3:0];
  end

  // backlight follows its control bit, one cycle after the write lands
  always_ff @(posedge clk_i)
  begin
    light_o <= !rst_i && ctrl_r[`DTC_CTRL_LIGHT_BIT];
  end

////////////////////////////////////////////////////////////////////////
// timers and counters, one per channel
  // previous event bits; reset matches the cleared event register, so no false edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_d_r <= 4'h0;
    else
      evt_d_r <= evt_r;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_chan
      // second timer
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          timer_r[g] <= 32'h0000_0000;
        else if (nv_state_r == DTC_NV_LOAD && nv_idx_r == 4'(g))
          timer_r[g] <= nv_rdata_i;
        else if (ctrl_wr && dat_i[`DTC_CTRL_TCLR_LSB + g])
          timer_r[g] <= 32'h0000_0000;
        else if (sec_tick_r && ctrl_r[`DTC_CTRL_TEN_LSB + g])
          timer_r[g] <= timer_r[g] + 32'h0000_0001;
      end
      // event counter
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          count_r[g] <= 32'h0000_0000;
        else if (nv_state_r == DTC_NV_LOAD && nv_idx_r == 4'(g + 4))
          count_r[g] <= nv_rdata_i;
        else if (ctrl_wr && dat_i[`DTC_CTRL_CCLR_LSB + g])
          count_r[g] <= 32'h0000_0000;
        else if (ready_r && evt_r[g] && !evt_d_r[g])
          count_r[g] <= count_r[g] + 32'h0000_0001;
      end
    end
  endgenerate

  // operating hours: no clear path exists
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hours_r <= 32'h0000_0000;
    else if (nv_state_r == DTC_NV_LOAD && nv_idx_r == 4'h8)
      hours_r <= nv_rdata_i;
    else if (sec_tick_r)
      hours_r <= hours_r + 32'h0000_0001;
  end

  // hours value fed to the display
  always_ff @(posedge clk_i)
  begin
    hours_disp_o <= rst_i ? 32'h0000_0000 : hours_r;
  end

////////////////////////////////////////////////////////////////////////
// display text and glyph store
  // supplied text length per row: bit 6 selects the row, bits 5:0 the length
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      row_len_r[0] <= `DTC_ROW_LEN_RST;
      row_len_r[1] <= `DTC_ROW_LEN_RST;
    end
    else if (wr_en && adr_i == `DTC_DISP_OFS && sel_i[0])
      row_len_r[dat_i[6]] <= dat_i[5:0];
  end

  // character cells, written as index in [12:8], code in [7:0]
  always_ff @(posedge clk_i)
  begin
    if (wr_en && adr_i == `DTC_CHAR_OFS && sel_i[1:0] == 2'h3)
      chars_r[dat_i[12:8]] <= dat_i[7:0];
  end

  // glyph rows: glyph in [11], row in [10:8], pixels in [4:0]
  always_ff @(posedge clk_i)
  begin
    if (wr_en && adr_i == `DTC_GLYPH_OFS && sel_i[1:0] == 2'h3)
      glyph_r[dat_i[11:8]] <= {3'h0, dat_i[4:0]};
  end

////////////////////////////////////////////////////////////////////////
// non-volatile save and restore sequencer
  // auto save interval; manual request set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      save_cnt_r <= 32'h0000_0000;
      save_req_r <= 1'b0;
    end
    else
    begin
      if (sec_tick_r && save_cnt_r == 32'(SAVE_SEC - 1))
        save_cnt_r <= 32'h0000_0000;
      else if (sec_tick_r)
        save_cnt_r <= save_cnt_r + 32'h0000_0001;
      if ((sec_tick_r && save_cnt_r == 32'(SAVE_SEC - 1))
          || (ctrl_wr && dat_i[`DTC_CTRL_SAVE_BIT]))
        save_req_r <= 1'b1;
      else if (nv_state_r == DTC_NV_IDLE && ready_r)
        save_req_r <= 1'b0;
    end
  end

  // sequencer: restore after reset, then write 9 words per save
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nv_state_r <= DTC_NV_LOAD;
      nv_idx_r <= 4'h0;
      ready_r <= 1'b0;
    end
    else
    begin
      case (nv_state_r)
        DTC_NV_IDLE:
          if (save_req_r)
          begin
            nv_state_r <= DTC_NV_WRITE;
            nv_idx_r <= 4'h0;
          end
        DTC_NV_WRITE:
          if (nv_idx_r == 4'h8)
            nv_state_r <= DTC_NV_IDLE;
          else
            nv_idx_r <= nv_idx_r + 4'h1;
        DTC_NV_LOAD:
          if (nv_idx_r == 4'h8)
          begin
            nv_state_r <= DTC_NV_IDLE;
            ready_r <= 1'b1;
          end
          else
            nv_idx_r <= nv_idx_r + 4'h1;
        default:
          nv_state_r <= DTC_NV_IDLE;
      endcase
    end
  end

  // store port, registered: word index drives read address too
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      nv_we_o <= 1'b0;
      nv_idx_o <= 4'h0;
      nv_wdata_o <= 32'h0000_0000;
    end
    else
    begin
      nv_we_o <= (nv_state_r == DTC_NV_WRITE);
      nv_idx_o <= nv_idx_r;
      nv_wdata_o <= (nv_idx_r[3]) ? hours_r :
                    (nv_idx_r[2]) ? count_r[nv_idx_r[1:0]] : timer_r[nv_idx_r[1:0]];
    end
  end

////////////////////////////////////////////////////////////////////////
// wishbone read and acknowledge, one wait state
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (adr_i)
      `DTC_CTRL_OFS: rd_mux = ctrl_r;
      `DTC_STAT_OFS: rd_mux = {24'h0, ready_r, (row_len_r[1] > 6'(`DTC_ROW_CELLS)),
                               (row_len_r[0] > 6'(`DTC_ROW_CELLS)), btn_r};
      `DTC_EVT_OFS: rd_mux = {28'h0, evt_r};
      `DTC_HOURS_OFS: rd_mux = hours_r;
      `DTC_DISP_OFS: rd_mux = {18'h0, row_len_r[1], 2'h0, row_len_r[0]};
      `DTC_NVLOAD_OFS: rd_mux = {28'h0, nv_idx_r};
      // timer and counter words, then paired row cells and glyph rows for readback
      default:
        if (adr_i[7:4] == 4'h2)
          rd_mux = timer_r[adr_i[3:2]];
        else if (adr_i[7:4] == 4'h3)
          rd_mux = count_r[adr_i[3:2]];
        else if (adr_i[7:6] == `DTC_CHAR_RD_SEL)
          rd_mux = {16'h0, chars_r[{1'b1, adr_i[5:2]}], chars_r[{1'b0, adr_i[5:2]}]};
        else if (adr_i[7:6] == `DTC_GLYPH_RD_SEL)
          rd_mux = {27'h0, glyph_r[adr_i[5:2]][4:0]};
    endcase
  end

  // ack and read data stand for exactly one cycle; data is zero otherwise
  always_ff @(posedge clk_i)
  begin
    ack_o <= !rst_i && wb_hit;
    dat_o <= (!rst_i && wb_hit && !we_i) ? rd_mux : 32'h0000_0000;
  end

endmodule
`default_nettype wire

//--- dtc_asserts.sv
/*
  port checker of dtc_top: bus answer, save bursts, backlight, hours.
  assumes it is bound onto dtc_top and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_asserts #(
  parameter int SEC_CYC = 10,
  parameter int SAVE_SEC = 3
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // outputs watched
  input wire logic light_o,
  input wire logic [31:0] hours_disp_o,
  input wire logic nv_we_o,
  input wire logic [3:0] nv_idx_o
);
  localparam int GAP_LIM = SAVE_SEC * SEC_CYC + 40; // slack covers restore
  int gap_r; // cycles since a save burst began
  logic take; // request taken this edge
  logic ctrl_wr; // control write taken
  assign take = cyc_i && stb_i && !ack_o;
  assign ctrl_wr = take && we_i && adr_i == 8'h00 && sel_i[1:0] == 2'b11;
  ////////////////
  // gap counter restarts at each burst start
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (nv_we_o && nv_idx_o == 4'h0))
      gap_r <= 0;
    else
      gap_r <= gap_r + 1;
  end
  ////////////////
  sequence s_start;
    $rose(nv_we_o) && nv_idx_o == 4'h0;
  endsequence
  sequence s_burst;
    nv_we_o[*8] ##1 (nv_we_o && nv_idx_o == 4'h8) ##1 !nv_we_o;
  endsequence
  property p_ack_resp;
    @(posedge clk_i) disable iff (rst_i) take |=> ack_o;
  endproperty
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  property p_dat_zero;
    @(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == 32'h0;
  endproperty
  property p_nv_burst;
    @(posedge clk_i) disable iff (rst_i) s_start |-> s_burst;
  endproperty
  property p_nv_step;
    @(posedge clk_i) disable iff (rst_i)
      nv_we_o && nv_idx_o != 4'h8 |=> nv_idx_o == $past(nv_idx_o) + 4'h1;
  endproperty
  property p_save_resp;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_wr && dat_i[12] |-> ##[1:24] (nv_we_o && nv_idx_o == 4'h0);
  endproperty
  property p_auto_gap;
    @(posedge clk_i) disable iff (rst_i) gap_r <= GAP_LIM;
  endproperty
  property p_light;
    @(posedge clk_i) disable iff (rst_i) ctrl_wr |=> ##1 light_o == $past(dat_i[13], 2);
  endproperty
  property p_hours_step;
    @(posedge clk_i) disable iff (rst_i)
      $past(hours_disp_o) != 32'h0 |-> hours_disp_o - $past(hours_disp_o) <= 32'h1;
  endproperty
  property p_rst_quiet;
    @(posedge clk_i) rst_i |=> !ack_o && !nv_we_o && !light_o && hours_disp_o == 32'h0;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_dat_zero: assert property (p_dat_zero) else $error("read data without ack");
  a_nv_burst: assert property (p_nv_burst) else $error("save burst not nine words");
  a_nv_step: assert property (p_nv_step) else $error("save index not ascending");
  a_save_resp: assert property (p_save_resp) else $error("save request not served");
  a_auto_gap: assert property (p_auto_gap) else $error("automatic save overdue");
  a_light: assert property (p_light) else $error("backlight not following control");
  a_hours_step: assert property (p_hours_step) else $error("hours jumped or cleared");
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
endmodule
bind dtc_top dtc_asserts #(.SEC_CYC(SEC_CYC), .SAVE_SEC(SAVE_SEC)) i_dtc_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .light_o(light_o),
  .hours_disp_o(hours_disp_o), .nv_we_o(nv_we_o), .nv_idx_o(nv_idx_o));
`default_nettype wire

//--- dtc_nv_model.sv
/*
  non-volatile store model: nine words, written one per strobe.
  assumes the restore reads word k in cycle k after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_nv_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // store port
  input wire logic we_i,
  input wire logic [3:0] idx_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:8]; // saved image, preset by the bench
  logic [3:0] cnt_r; // cycles since reset release
  logic tgl_r; // junk pattern toggle
  ////////////////
  // store each word written
  always @(posedge clk_i)
  begin
    if (we_i && idx_i < 4'h9)
      mem[idx_i] <= wdata_i;
  end
  // restore window count
  always @(posedge clk_i)
  begin
    tgl_r <= rst_i ? 1'b0 : !tgl_r;
    if (rst_i)
      cnt_r <= 4'h0;
    else if (cnt_r != 4'hF)
      cnt_r <= cnt_r + 4'h1;
  end
  // outside the window the data is not held, so show a changing pattern
  assign rdata_o = (cnt_r < 4'h9) ? mem[cnt_r] : {32{tgl_r}} ^ 32'hA5A5_5A5A;
endmodule
`default_nettype wire

//--- tb_top.sv
/*
  self-checking bench of dtc_top with a store model.
  assumes short second and save counts through the parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int SEC = 10; // cycles per second
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, light_o, nv_we_o;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 4'hF;
  logic [4:0] btn_i = 0;
  logic [3:0] nv_idx_o, pv, p, t, en;
  logic [31:0] dat_i = 0, dat_o, hours_disp_o, nv_wdata_o, nv_rdata_i, q, pre [0:8], ec [0:3];
  int n_fail = 0, compares = 0, cycles = 0, n_save = 0, k, b;
  dtc_top #(.SEC_CYC(SEC), .SAVE_SEC(3)) i_dtc_top (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .btn_i(btn_i), .light_o(light_o),
    .hours_disp_o(hours_disp_o), .nv_we_o(nv_we_o), .nv_idx_o(nv_idx_o),
    .nv_wdata_o(nv_wdata_o), .nv_rdata_i(nv_rdata_i));
  dtc_nv_model i_dtc_nv_model (.clk_i(clk_i), .rst_i(rst_i), .we_i(nv_we_o),
    .idx_i(nv_idx_o), .wdata_i(nv_wdata_o), .rdata_o(nv_rdata_i));
  ////////////////
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard and save counter
  always @(posedge clk_i)
  begin
    cycles++;
    if (nv_we_o === 1'b1 && nv_idx_o === 4'h8)
      n_save++;
    if (cycles > 20000)
    begin
      n_fail++;
      end_of_test();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 100);
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    if (n >= 100)
      n_fail++;
  endtask
  function automatic logic in_win(input logic [31:0] v, input int c);
    return v >= c - 1 && v <= c + 1;
  endfunction
  task end_of_test;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////
  initial
  begin
    void'($urandom(37039));
    for (k = 0; k < 9; k++)
    begin
      pre[k] = (k == 4) ? 32'hFFFF_FFFF : $urandom;
      i_dtc_nv_model.mem[k] = pre[k];
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    q = 0;
    for (k = 0; k < 50 && q[7] !== 1'b1; k++)
      wb(0, 8'h04, 0);
    wb(0, 8'h0C, 0);
    chk(q - pre[8] <= 32'h1, 1);
    chk(q - hours_disp_o <= 32'h1, 1);
    for (k = 0; k < 4; k++)
    begin
      wb(0, 8'(8'h20 + 4 * k), 0);
      chk(q, pre[k]);
      wb(0, 8'(8'h30 + 4 * k), 0);
      chk(q, pre[k + 4]);
    end
    wb(1, 8'h08, 1);
    wb(0, 8'h30, 0);
    chk(q, 0);
    wb(1, 8'h08, 0);
    wb(1, 8'h00, 32'h0000_0FF0);
    pv = 0;
    ec = '{default: 32'h0};
    repeat (20)
    begin
      p = 4'($urandom);
      t = p & ~pv;
      for (b = 0; b < 4; b++)
        ec[b] += t[b];
      wb(1, 8'h08, {28'h0, p});
      pv = p;
    end
    en = 4'($urandom);
    wb(1, 8'h00, {28'h0, en});
    repeat (5 * SEC) @(posedge clk_i);
    wb(1, 8'h00, 0);
    for (k = 0; k < 4; k++)
    begin
      wb(0, 8'(8'h30 + 4 * k), 0);
      chk(q, ec[k]);
      wb(0, 8'(8'h20 + 4 * k), 0);
      chk(en[k] ? in_win(q, 5) : q === 0, 1);
    end
    wb(1, 8'h00, 32'h0000_30F0);
    repeat (30) @(posedge clk_i);
    chk(light_o, 1);
    for (k = 0; k < 4; k++)
    begin
      chk(i_dtc_nv_model.mem[k], 0);
      chk(i_dtc_nv_model.mem[k + 4], ec[k]);
    end
    chk(hours_disp_o - i_dtc_nv_model.mem[8] <= 32'h4, 1);
    wb(1, 8'h00, 0);
    repeat (3) @(posedge clk_i);
    chk(light_o, 0);
    // control write without both low byte enables is refused
    sel_i <= 4'hC;
    wb(1, 8'h00, 32'h0000_2000);
    sel_i <= 4'hF;
    repeat (3) @(posedge clk_i);
    chk(light_o, 0);
    repeat (4)
    begin
      btn_i <= 5'($urandom);
      repeat (8) @(posedge clk_i);
      wb(0, 8'h04, 0);
      chk(q[4:0], btn_i);
    end
    for (k = 0; k < 4; k++)
    begin
      wb(1, 8'h10, {25'h0, k[1], 6'(16 + k[0])});
      wb(0, 8'h04, 0);
      chk(q[5 + k[1]], k[0]);
    end
    for (k = 0; k < 2; k++)
    begin
      pre[k] = $urandom;
      wb(1, 8'h40, {19'h0, k[0], 4'h3, pre[k][7:0]});
    end
    wb(0, 8'h4C, 0);
    chk(q, {16'h0, pre[1][7:0], pre[0][7:0]});
    b = $urandom;
    wb(1, 8'h14, {20'h0, 4'hD, 3'h0, b[4:0]});
    wb(0, 8'hB4, 0);
    chk(q, {27'h0, b[4:0]});
    wb(0, 8'h1C, 0);
    chk(q, 0);
    chk(n_save >= 2, 1);
    end_of_test();
  end
endmodule
`default_nettype wire
